// *** inc/asq_pkg.sv ***
// asq_pkg: register map, field layout and types for the converter sequence/result/oversampler block
// assumes a single clock domain and the plain strobe register port
package asq_pkg;
  localparam logic [7:0] OFS_SLOT_MID   = 8'h30;
  localparam logic [7:0] OFS_SLOT_LOW   = 8'h34;
  localparam logic [7:0] OFS_RESULT     = 8'h4c;
  localparam logic [7:0] OFS_OVS_CTL    = 8'h80;
  localparam logic [7:0] OFS_SEQ_CTL    = 8'h84;
  localparam logic [7:0] OFS_SEQ_STAT   = 8'h88;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [31:0] SLOT_MASK     = 32'h3fff_ffff;
  localparam logic [31:0] OVS_MASK      = 32'h0000_33fd;
  localparam logic [31:0] SEQ_CTL_MASK  = 32'h0000_00f1;
  localparam int SLOT_W        = 5;
  localparam int SLOTS_PER_REG = 6;
  localparam int NUM_SLOTS     = 12;
  localparam int POS_OVERSAMPLER_ENABLE     = 0;
  localparam int POS_RATIO     = 2;
  localparam int POS_SHIFT     = 5;
  localparam int POS_PER_TRIGGER_OVERSAMPLING      = 9;
  localparam int POS_RES       = 12;
  localparam int POS_CONV_ON   = 0;
  localparam int POS_LEN       = 4;
  localparam logic [3:0] MAX_SHIFT = 4'h8;
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_10 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;
  localparam int ACC_W = 20;

  typedef struct packed {
    logic [1:0] resolution_select;
    logic       per_trigger_oversampling;
    logic [3:0] oversample_shift;
    logic [2:0] oversample_ratio;
    logic       oversampler_enable;
  } asq_ovs_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } asq_bus_t;
endpackage : asq_pkg

// *** rtl/asq_regs.sv ***
// asq_regs: routine slot registers, routine result, oversampler control and accumulator
// assumes the analog core reports each conversion with conv_done/conv_data and
// that the second converter's result arrives on a separate port in sync mode
//
// Contract
// - slot field selects channel per position
// - six five-bit slots packed per register
// - low half returns latest result, read-only
// - upper half holds second converter result in sync mode, reads zero otherwise
// - resolution code selects 12/10/8/6 bits
// - per_trigger_oversampling clear: one trigger, all conversions
// - per_trigger_oversampling set: one trigger per conversion
// - shift field right-shifts sum, zero to eight
// - ratio code gives two^(code+1) samples
// - bit 0 enables oversampler, software only
// - sequence runs length plus one slots
`timescale 1ns/1ps
`default_nettype none
module asq_regs
  import asq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire asq_bus_t    bus,
  output logic      [31:0] rdata,
  input  wire logic        trigger,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  input  wire logic        sync_mode,
  input  wire logic        second_valid,
  input  wire logic [15:0] second_converter_result,
  output logic             conv_start,
  output logic       [4:0] conv_channel,
  output logic       [1:0] resolution_select,
  output logic             converter_on,
  output logic             result_valid
);

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_WAIT_TRIG} asq_state_t;

  function automatic logic hit(input asq_bus_t b, input logic [7:0] ofs);
    return b.addr == ofs;
  endfunction : hit

  function automatic logic [4:0] slot_of(input logic [59:0] slots, input logic [3:0] idx);
    // upper slots live outside this block; a long sequence reads them as channel zero, not X
    if (idx >= NUM_SLOTS) return '0;
    return slots[idx*SLOT_W +: SLOT_W];
  endfunction : slot_of

  logic [31:0] slot_mid_r;
  logic [31:0] slot_low_r;
  logic [31:0] ovs_word_r;
  asq_ovs_t    ovs;
  logic        conv_on_r;
  logic [3:0]  seq_len_r;
  logic [15:0] result_r;
  logic [15:0] second_r;
  logic [ACC_W-1:0] acc_r;
  logic [8:0]  ovs_cnt_r;
  logic [3:0]  slot_idx_r;
  asq_state_t  state_r;
  logic [59:0] slots;
  logic [8:0]  ratio_n;
  logic        ovs_last;
  logic        seq_last;
  logic [ACC_W-1:0] acc_sum;
  logic [ACC_W-1:0] shifted;

  assign ovs = '{resolution_select:        ovs_word_r[POS_RES +: 2],
                 per_trigger_oversampling: ovs_word_r[POS_PER_TRIGGER_OVERSAMPLING],
                 oversample_shift:         ovs_word_r[POS_SHIFT +: 4],
                 oversample_ratio:         ovs_word_r[POS_RATIO +: 3],
                 oversampler_enable:       ovs_word_r[POS_OVERSAMPLER_ENABLE]};

  // slots 0..5 sit in the low register, 6..11 in the mid register
  genvar g;
  generate
    for (g = 0; g < SLOTS_PER_REG; g++) begin : g_slots
      assign slots[g*SLOT_W +: SLOT_W]                 = slot_low_r[g*SLOT_W +: SLOT_W];
      assign slots[(g+SLOTS_PER_REG)*SLOT_W +: SLOT_W] = slot_mid_r[g*SLOT_W +: SLOT_W];
    end
  endgenerate

  assign ratio_n  = 9'(2) << ovs.oversample_ratio;
  assign ovs_last = !ovs.oversampler_enable || (ovs_cnt_r == ratio_n - 9'(1));
  assign seq_last = slot_idx_r == seq_len_r;
  assign acc_sum  = acc_r + ACC_W'(conv_data);
  // reserved shift codes clamp to eight so the result stays defined
  assign shifted  = acc_sum >> ((ovs.oversample_shift > MAX_SHIFT) ? MAX_SHIFT : ovs.oversample_shift);

  assign conv_channel      = slot_of(slots, slot_idx_r);
  assign resolution_select = ovs.resolution_select;
  assign converter_on      = conv_on_r;
  assign conv_start        = (state_r == ST_IDLE && conv_on_r && trigger) ||
                             (state_r == ST_WAIT_TRIG && trigger);

  // register writes; result register has no write path
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_mid_r <= RST_WORD;
      slot_low_r <= RST_WORD;
      ovs_word_r <= RST_WORD;
      conv_on_r  <= 1'b0;
      seq_len_r  <= '0;
    end else if (bus.wr) begin
      if (hit(bus, OFS_SLOT_MID)) slot_mid_r <= bus.wdata & SLOT_MASK;
      if (hit(bus, OFS_SLOT_LOW)) slot_low_r <= bus.wdata & SLOT_MASK;
      if (hit(bus, OFS_OVS_CTL))  ovs_word_r <= bus.wdata & OVS_MASK;
      if (hit(bus, OFS_SEQ_CTL)) begin
        conv_on_r <= bus.wdata[POS_CONV_ON];
        seq_len_r <= bus.wdata[POS_LEN +: 4];
      end
    end
  end

  // sequence and oversampling state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_IDLE;
      slot_idx_r <= '0;
      ovs_cnt_r  <= '0;
      acc_r      <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          slot_idx_r <= '0;
          ovs_cnt_r  <= '0;
          acc_r      <= '0;
          if (conv_start) state_r <= ST_CONV;
        end
        ST_CONV: begin
          if (!conv_on_r) begin
            state_r <= ST_IDLE;
          end else if (conv_done) begin
            if (!ovs_last) begin
              acc_r     <= acc_sum;
              ovs_cnt_r <= ovs_cnt_r + 9'(1);
              if (ovs.per_trigger_oversampling) state_r <= ST_WAIT_TRIG;
              else state_r <= ST_CONV;
            end else begin
              acc_r     <= '0;
              ovs_cnt_r <= '0;
              if (seq_last) begin
                state_r <= ST_IDLE;
              end else begin
                slot_idx_r <= slot_idx_r + 4'(1);
                // next slot restarts with a trigger only under per-trigger mode
                state_r <= ovs.per_trigger_oversampling ? ST_WAIT_TRIG : ST_CONV;
              end
            end
          end
        end
        ST_WAIT_TRIG: begin
          if (!conv_on_r) state_r <= ST_IDLE;
          else if (trigger) state_r <= ST_CONV;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // result capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_r     <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      if (state_r == ST_CONV && conv_on_r && conv_done && ovs_last) begin
        result_r     <= ovs.oversampler_enable ? shifted[15:0] : conv_data;
        result_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) second_r <= '0;
    else if (sync_mode && second_valid) second_r <= second_converter_result;
  end

  // read port: data valid the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= RST_WORD;
    end else if (bus.rd) begin
      if (hit(bus, OFS_SLOT_MID))      rdata <= slot_mid_r;
      else if (hit(bus, OFS_SLOT_LOW)) rdata <= slot_low_r;
      else if (hit(bus, OFS_RESULT))   rdata <= {sync_mode ? second_r : 16'h0000, result_r};
      else if (hit(bus, OFS_OVS_CTL))  rdata <= ovs_word_r;
      else if (hit(bus, OFS_SEQ_CTL))  rdata <= {24'h00_0000, seq_len_r, 3'h0, conv_on_r};
      else if (hit(bus, OFS_SEQ_STAT)) rdata <= {19'h0_0000, ovs_cnt_r, slot_idx_r} & 32'h0000_1fff;
      else rdata <= RST_WORD;
    end else begin
      rdata <= RST_WORD;
    end
  end

  // checks
  property p_slot_pack;
    @(posedge clk) disable iff (!reset_n)
      slot_idx_r == 4'd6 |-> conv_channel == slot_mid_r[4:0];
  endproperty
  a_slot_pack: assert property (p_slot_pack) else $error("slot 6 not from mid register");

  property p_chan0;
    @(posedge clk) disable iff (!reset_n)
      slot_idx_r == 4'd0 |-> conv_channel == slot_low_r[4:0];
  endproperty
  a_chan0: assert property (p_chan0) else $error("slot 0 channel wrong");

  property p_result_ro;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == OFS_RESULT && !result_valid) |=> $stable(result_r) || result_valid;
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result changed by write");

  property p_second;
    @(posedge clk) disable iff (!reset_n)
      (sync_mode && second_valid) |=> second_r == $past(second_converter_result);
  endproperty
  a_second: assert property (p_second) else $error("second result not captured");

  property p_res;
    @(posedge clk) disable iff (!reset_n)
      resolution_select == ovs_word_r[13:12];
  endproperty
  a_res: assert property (p_res) else $error("resolution output mismatch");

  property p_per_trigger_oversampling_clear;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_CONV && conv_on_r && conv_done && !ovs_last && !ovs.per_trigger_oversampling)
        |=> state_r == ST_CONV;
  endproperty
  a_per_trigger_oversampling_clear: assert property (p_per_trigger_oversampling_clear) else $error("waited for trigger with per_trigger_oversampling clear");

  property p_per_trigger_oversampling_set;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_CONV && conv_on_r && conv_done && !ovs_last && ovs.per_trigger_oversampling)
        |=> state_r == ST_WAIT_TRIG;
  endproperty
  a_per_trigger_oversampling_set: assert property (p_per_trigger_oversampling_set) else $error("no trigger wait with per_trigger_oversampling set");

  property p_ratio;
    @(posedge clk) disable iff (!reset_n)
      ovs.oversampler_enable |-> ovs_cnt_r < ratio_n && ratio_n == (9'd2 << ovs_word_r[4:2]);
  endproperty
  a_ratio: assert property (p_ratio) else $error("oversample count out of range");

  property p_len;
    @(posedge clk) disable iff (!reset_n)
      state_r != ST_IDLE |-> slot_idx_r <= seq_len_r;
  endproperty
  a_len: assert property (p_len) else $error("slot index past sequence length");

  property p_enable;
    @(posedge clk) disable iff (!reset_n)
      (bus.wr && bus.addr == OFS_OVS_CTL) |=> ovs.oversampler_enable == $past(bus.wdata[0]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit not written");

  property p_plain;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_CONV && conv_on_r && conv_done && !ovs.oversampler_enable)
        |=> result_valid && result_r == $past(conv_data);
  endproperty
  a_plain: assert property (p_plain) else $error("plain result not presented");

  property p_slot_one;
    @(posedge clk) disable iff (!reset_n)
      slot_idx_r == 4'h1 |-> conv_channel == slot_low_r[SLOT_W +: SLOT_W];
  endproperty
  a_slot_one: assert property (p_slot_one) else $error("slot 1 channel wrong");

  // trigger handling
  property p_start_trig;
    @(posedge clk) disable iff (!reset_n)
      conv_start |-> trigger;
  endproperty
  a_start_trig: assert property (p_start_trig) else $error("conversion started without trigger");

  property p_no_start_off;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_IDLE && !conv_on_r) |-> !conv_start;
  endproperty
  a_no_start_off: assert property (p_no_start_off) else $error("conversion started while converter off");

  property p_wait_hold;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_WAIT_TRIG && conv_on_r && !trigger) |=> state_r == ST_WAIT_TRIG;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left trigger wait without trigger");

  // oversampling arithmetic
  property p_accum;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_CONV && conv_on_r && conv_done && !ovs_last)
        |=> acc_r == $past(acc_r) + ACC_W'($past(conv_data));
  endproperty
  a_accum: assert property (p_accum) else $error("oversample sum not accumulated");

  property p_ovs_result;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_CONV && conv_on_r && conv_done && ovs_last && ovs.oversampler_enable &&
       ovs.oversample_shift <= MAX_SHIFT)
        |=> result_valid && result_r == $past(16'((acc_r + ACC_W'(conv_data)) >> ovs.oversample_shift));
  endproperty
  a_ovs_result: assert property (p_ovs_result) else $error("oversampled result not shifted sum");

  // sequence stepping
  property p_slot_step;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_CONV && conv_on_r && conv_done && ovs_last && !seq_last)
        |=> slot_idx_r == $past(slot_idx_r) + 4'h1;
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("sequence did not advance one slot");

  property p_seq_end;
    @(posedge clk) disable iff (!reset_n)
      (state_r == ST_CONV && conv_on_r && conv_done && ovs_last && seq_last) |=> state_r == ST_IDLE;
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("sequence ran past its length");

  // read port
  property p_rd_result;
    @(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == OFS_RESULT) |=> rdata[15:0] == $past(result_r);
  endproperty
  a_rd_result: assert property (p_rd_result) else $error("result read returned stale data");

  property p_rd_second;
    @(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == OFS_RESULT)
        |=> rdata[31:16] == ($past(sync_mode) ? $past(second_r) : 16'h0000);
  endproperty
  a_rd_second: assert property (p_rd_second) else $error("upper result half wrong");

  property p_rdata_idle;
    @(posedge clk) disable iff (!reset_n)
      !bus.rd |=> rdata == RST_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data present without read");

  property p_ovs_rd;
    @(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == OFS_OVS_CTL) |=> rdata[POS_OVERSAMPLER_ENABLE] == $past(ovs.oversampler_enable);
  endproperty
  a_ovs_rd: assert property (p_ovs_rd) else $error("enable bit read back wrong");

endmodule : asq_regs
`default_nettype wire

// *** tb/asq_regs_bench.sv ***
// asq_regs_bench: self-checking bench for slot, result and oversampler registers
// assumes asq_pkg and asq_regs compiled first; bench stands in for bus master and analog core
`timescale 1ns/1ps
`default_nettype none
module asq_regs_bench
  import asq_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  asq_bus_t    bus = '0;
  logic [31:0] rdata;
  logic        trigger = 1'b0;
  logic        conv_done = 1'b0;
  logic [15:0] conv_data = 16'h0000;
  logic        sync_mode = 1'b0;
  logic        second_valid = 1'b0;
  logic [15:0] second_converter_result = 16'h0000;
  logic        conv_start;
  logic [4:0]  conv_channel;
  logic [1:0]  resolution_select;
  logic        converter_on;
  logic        result_valid;
  int          bad_count = 0;
  int          n_compared = 0;

  always #20 clk = ~clk;

  asq_regs asq_regs_inst (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .trigger(trigger), .conv_done(conv_done), .conv_data(conv_data), .sync_mode(sync_mode),
    .second_valid(second_valid), .second_converter_result(second_converter_result),
    .conv_start(conv_start), .conv_channel(conv_channel), .resolution_select(resolution_select),
    .converter_on(converter_on), .result_valid(result_valid));

  task automatic complete_run();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // strobes dropped one edge later, so back-to-back calls never reassign in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= {a, d, 2'b10};
    @(posedge clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= {a, 32'h0000_0000, 2'b01};
    @(posedge clk);
    bus <= '0;
    #1 cmp(rdata, exp);
  endtask : rd

  // conv_start is combinational, so it is judged inside the trigger cycle
  task automatic pulse_trig();
    @(posedge clk);
    trigger <= 1'b1;
    #1 cmp({31'h0, conv_start}, 32'h1);
    @(posedge clk);
    trigger <= 1'b0;
  endtask : pulse_trig

  task automatic conv(input logic [15:0] d);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask : conv

  task automatic wait_rv();
    for (int i = 0; i < 16; i++) begin
      #1;
      if (result_valid === 1'b1) return;
      @(posedge clk);
    end
    bad_count++;
    $display("mismatch at %0t: result never updated", $time);
    complete_run();
  endtask : wait_rv

  task automatic t_reset();
    rd(OFS_SLOT_LOW, 32'h0000_0000);
    rd(OFS_RESULT, 32'h0000_0000);
    rd(OFS_OVS_CTL, 32'h0000_0000);
    cmp({27'h0, conv_channel}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_slots();
    wr(OFS_SLOT_LOW, 32'h3fff_ffff);
    rd(OFS_SLOT_LOW, 32'h3fff_ffff);
    cmp({27'h0, conv_channel}, 32'h0000_001f);
    wr(OFS_SLOT_MID, 32'h3fff_ffff);
    rd(OFS_SLOT_MID, 32'h3fff_ffff);
    wr(8'h40, 32'h1234_5678);
    rd(8'h40, 32'h0000_0000);
    wr(OFS_SLOT_LOW, 32'h0000_00e3);
  endtask : t_slots

  task automatic t_ovs_reg();
    wr(OFS_OVS_CTL, 32'h0000_331d);
    rd(OFS_OVS_CTL, 32'h0000_331d);
    for (int r = 3; r >= 0; r--) begin
      wr(OFS_OVS_CTL, 32'(r) << 12);
      #1 cmp({30'h0, resolution_select}, 32'(r));
    end
    wr(OFS_RESULT, 32'hffff_ffff);
    rd(OFS_RESULT, 32'h0000_0000);
  endtask : t_ovs_reg

  // two-slot run: channel must step from slot 0 to slot 1
  task automatic t_plain();
    wr(OFS_SEQ_CTL, 32'h0000_0011);
    #1 cmp({27'h0, conv_channel}, 32'h0000_0003);
    cmp({31'h0, converter_on}, 32'h1);
    pulse_trig();
    conv(16'h0abc);
    wait_rv();
    cmp({27'h0, conv_channel}, 32'h0000_0007);
    rd(OFS_RESULT, 32'h0000_0abc);
    conv(16'h0123);
    wait_rv();
    rd(OFS_RESULT, 32'h0000_0123);
    wr(OFS_SEQ_CTL, 32'h0000_0000);
  endtask : t_plain

  task automatic t_ovs_run();
    #1 cmp({31'h0, converter_on}, 32'h0);
    wr(OFS_OVS_CTL, 32'h0000_0021);
    wr(OFS_SEQ_CTL, 32'h0000_0001);
    pulse_trig();
    conv(16'h0064);
    conv(16'h00c8);
    wait_rv();
    rd(OFS_RESULT, 32'h0000_0096);
    wr(OFS_SEQ_CTL, 32'h0000_0000);
  endtask : t_ovs_run

  task automatic t_per_trigger_oversampling();
    wr(OFS_OVS_CTL, 32'h0000_0245);
    wr(OFS_SEQ_CTL, 32'h0000_0001);
    for (int k = 1; k <= 4; k++) begin
      pulse_trig();
      conv(16'(4 * k));
      if (k < 4) begin
        #1 cmp({31'h0, result_valid}, 32'h0);
      end
    end
    wait_rv();
    rd(OFS_RESULT, 32'h0000_000a);
    wr(OFS_SEQ_CTL, 32'h0000_0000);
  endtask : t_per_trigger_oversampling

  task automatic t_sync();
    @(posedge clk);
    sync_mode <= 1'b1;
    second_valid <= 1'b1;
    second_converter_result <= 16'h5a5a;
    @(posedge clk);
    second_valid <= 1'b0;
    rd(OFS_RESULT, 32'h5a5a_000a);
    @(posedge clk);
    sync_mode <= 1'b0;
    rd(OFS_RESULT, 32'h0000_000a);
  endtask : t_sync

  // seven-slot run reaches slot 6, the first slot held in the mid register
  task automatic t_long();
    wr(OFS_OVS_CTL, 32'h0000_0000);
    wr(OFS_SLOT_MID, 32'h0000_0011);
    wr(OFS_SEQ_CTL, 32'h0000_0061);
    pulse_trig();
    for (int k = 0; k < 6; k++) begin
      conv(16'h0000);
    end
    #1 cmp({27'h0, conv_channel}, 32'h0000_0011);
    conv(16'h0077);
    wait_rv();
    rd(OFS_RESULT, 32'h0000_0077);
    wr(OFS_SEQ_CTL, 32'h0000_0000);
  endtask : t_long

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_slots();
    t_ovs_reg();
    t_plain();
    t_ovs_run();
    t_per_trigger_oversampling();
    t_sync();
    t_long();
    complete_run();
  end
endmodule : asq_regs_bench
`default_nettype wire
